// file: rtl/cac_capture_alarm.sv
// Operation
// R1 - Window field picks rectangular, Hanning, flat top
// R2 - Four enable bits, one per rate
// R3 - Rate enables matter only in capture modes
// R4 - Rotate enabled rates on successive captures
// R5 - Power-down bit sleeps after capture completes
// R6 - Chip-select toggle wakes a sleeping device; the code does not wake it while in CAC_WAIT (automatic mode)
// R7 - Automatic mode wakes itself before capture
// R8 - Statistics only when enable bit set
// R9 - Velocity bit selects velocity buffer contents
// R10 - Two-bit field chooses record storage policy
// R11 - Low two bits select operating mode
// R12 - Time capture mode encodes as 10
// R13 - Manual 00, automatic 01 encodings
// R14 - Period register counts seconds between captures
// R15 - Six bands, pointer selects band configured
// R16 - Low bin starts selected band
// R17 - High bin ends selected band
// R18 - Warning raised when magnitude reaches level
// R19 - Host keeps critical level above warning
// R20 - Levels compare in buffer data format
// R21 - Pointer holds rate and band fields
// R22 - Pointer write loads; writes update selected
// R23 - System level watches temperature or supply
// R24 - Alarms latched per completed capture event
`timescale 1ns/1ps
`default_nettype none
module cac_capture_alarm #(
  parameter longint CYC_PER_SEC = cac_pkg::CYC_PER_UNIT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial register port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  // Capture datapath
  input wire logic capture_req,
  input wire logic capture_done,
  input wire logic [cac_pkg::NUM_BANDS*16-1:0] band_peak,
  input wire logic [15:0] sys_reading,
  output logic capture_start,
  output logic [1:0] capture_rate,
  output logic [1:0] window_sel,
  output logic stats_en,
  output logic velocity_en,
  output logic [1:0] store_mode,
  output logic [1:0] op_mode,
  output logic sys_temp_sel,
  output logic sleep
);
  import cac_pkg::*;

  typedef struct packed {
    logic sck;
    logic cs;
    logic [15:0] rx;
    logic [4:0] nbits;
    logic [15:0] tx;
    logic [15:0] rd_word;
    logic dout;
    logic [15:0] recording_control;
    logic [15:0] period;
    logic [15:0] low_bin;
    logic [15:0] high_bin;
    logic [15:0] warn_lvl;
    logic [15:0] crit_lvl;
    logic [15:0] pntr;
    logic [15:0] sys_lvl;
    logic [15:0] alm_cfg;
    logic [12:0] flags;
    logic [3:0][5:0][3:0][15:0] mem;
    cac_state_t state;
    logic [1:0] last_rate;
    logic [1:0] rate;
    logic [24:0] sec_cnt;
    logic [15:0] prd_cnt;
    logic start;
    logic sleep;
    logic stats;
  } cac_st_t;

  cac_st_t st_q;
  cac_st_t st_d;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  function automatic logic [1:0] next_rate(input logic [3:0] en, input logic [1:0] cur);
    logic [1:0] c;
    logic hit;
    next_rate = 2'h0;
    hit = 1'b0;
    c = cur;
    for (int i = 0; i < NUM_RATES; i++) begin
      c = c + 2'h1;
      if (!hit && en[c]) begin
        next_rate = c;
        hit = 1'b1;
      end
    end
  endfunction

  function automatic logic capture_mode(input logic [1:0] m);
    capture_mode = (m == MODE_MANUAL_SPECTRUM) || (m == MODE_AUTO_SPECTRUM) ||
                   (m == MODE_TIME_CAPTURE); // R3 R12 R13
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [1:0] mode;
    logic [1:0] prate;
    logic [2:0] pband;
    logic [6:0] adr;
    logic hi;
    logic [7:0] wb;
    logic fire;
    logic [15:0] peak;
    logic [15:0] w1;
    logic [15:0] w2;
    mode = 2'h0;
    prate = 2'h0;
    pband = 3'h0;
    adr = 7'h0;
    hi = 1'b0;
    wb = 8'h0;
    fire = 1'b0;
    peak = 16'h0;
    w1 = 16'h0;
    w2 = 16'h0;
    st_d = st_q;
    st_d.start = 1'b0;
    st_d.sck = sclk;
    st_d.cs = !cs_n;

    // Serial shifting: sample on rising, shift out on falling
    if (!cs_n && !st_q.cs) begin
      st_d.nbits = 5'h0;
      st_d.tx = st_q.rd_word;
      st_d.dout = st_q.rd_word[15];
      if (st_q.sleep && st_q.state != CAC_WAIT) begin
        st_d.sleep = 1'b0; // R6
      end
    end else if (!cs_n) begin
      if (sclk && !st_q.sck) begin
        st_d.rx = {st_q.rx[14:0], din};
        if (st_q.nbits != 5'(FRAME_BITS)) begin
          st_d.nbits = st_q.nbits + 5'h1;
        end
      end else if (!sclk && st_q.sck && st_q.nbits != 5'h0) begin
        st_d.tx = {st_q.tx[14:0], 1'b0};
        st_d.dout = st_q.tx[14];
      end
    end

    // Frame complete at chip-select release
    if (cs_n && st_q.cs && st_q.nbits == 5'(FRAME_BITS)) begin
      adr = st_q.rx[FRM_ADDR_HI:FRM_ADDR_LO];
      hi = adr[0];
      wb = st_q.rx[7:0];
      if (st_q.rx[FRM_WR_BIT]) begin
        prate = st_q.pntr[PNTR_RATE_LO +: 2];
        pband = st_q.pntr[PNTR_BAND_LO +: 3];
        if ({adr[6:1], 1'b0} == ADR_RECORDING_CONTROL) begin
          st_d.recording_control = put_byte(st_q.recording_control, hi, wb); // R1 R2 R5 R9 R10 R11
        end else if ({adr[6:1], 1'b0} == ADR_CAP_PERIOD) begin
          st_d.period = put_byte(st_q.period, hi, wb); // R14
        end else if ({adr[6:1], 1'b0} == ADR_LOW_BIN) begin
          st_d.low_bin = put_byte(st_q.low_bin, hi, wb); // R16
          if (pband < 3'(NUM_BANDS)) st_d.mem[prate][pband][0] = st_d.low_bin; // R22
        end else if ({adr[6:1], 1'b0} == ADR_HIGH_BIN) begin
          st_d.high_bin = put_byte(st_q.high_bin, hi, wb); // R17
          if (pband < 3'(NUM_BANDS)) st_d.mem[prate][pband][1] = st_d.high_bin; // R22
        end else if ({adr[6:1], 1'b0} == ADR_WARN_LVL) begin
          st_d.warn_lvl = put_byte(st_q.warn_lvl, hi, wb);
          if (pband < 3'(NUM_BANDS)) st_d.mem[prate][pband][2] = st_d.warn_lvl; // R22
        end else if ({adr[6:1], 1'b0} == ADR_CRIT_LVL) begin
          st_d.crit_lvl = put_byte(st_q.crit_lvl, hi, wb);
          if (pband < 3'(NUM_BANDS)) st_d.mem[prate][pband][3] = st_d.crit_lvl; // R22
        end else if ({adr[6:1], 1'b0} == ADR_ALARM_SELECT_POINTER) begin
          st_d.pntr = put_byte(st_q.pntr, hi, wb) & 16'h0307; // R21
          prate = st_d.pntr[PNTR_RATE_LO +: 2];
          pband = st_d.pntr[PNTR_BAND_LO +: 3];
          if (pband < 3'(NUM_BANDS)) begin
            st_d.low_bin = st_q.mem[prate][pband][0]; // R15 R22
            st_d.high_bin = st_q.mem[prate][pband][1];
            st_d.warn_lvl = st_q.mem[prate][pband][2];
            st_d.crit_lvl = st_q.mem[prate][pband][3];
          end else begin
            st_d.low_bin = RST_ZERO;
            st_d.high_bin = RST_ZERO;
            st_d.warn_lvl = RST_ZERO;
            st_d.crit_lvl = RST_ZERO;
          end
        end else if ({adr[6:1], 1'b0} == ADR_SYS_LVL) begin
          st_d.sys_lvl = put_byte(st_q.sys_lvl, hi, wb); // R23
        end else if ({adr[6:1], 1'b0} == ADR_ALM_CFG) begin
          st_d.alm_cfg = put_byte(st_q.alm_cfg, hi, wb);
        end else if ({adr[6:1], 1'b0} == ADR_ALM_STATUS) begin
          // Write one to clear; a same-cycle event is applied later and wins
          w1 = put_byte(16'h0, hi, wb);
          st_d.flags = st_q.flags & ~w1[12:0];
        end
      end else begin
        if ({adr[6:1], 1'b0} == ADR_RECORDING_CONTROL) st_d.rd_word = st_q.recording_control;
        else if ({adr[6:1], 1'b0} == ADR_CAP_PERIOD) st_d.rd_word = st_q.period;
        else if ({adr[6:1], 1'b0} == ADR_LOW_BIN) st_d.rd_word = st_q.low_bin;
        else if ({adr[6:1], 1'b0} == ADR_HIGH_BIN) st_d.rd_word = st_q.high_bin;
        else if ({adr[6:1], 1'b0} == ADR_WARN_LVL) st_d.rd_word = st_q.warn_lvl;
        else if ({adr[6:1], 1'b0} == ADR_CRIT_LVL) st_d.rd_word = st_q.crit_lvl;
        else if ({adr[6:1], 1'b0} == ADR_ALARM_SELECT_POINTER) st_d.rd_word = st_q.pntr;
        else if ({adr[6:1], 1'b0} == ADR_SYS_LVL) st_d.rd_word = st_q.sys_lvl;
        else if ({adr[6:1], 1'b0} == ADR_ALM_CFG) st_d.rd_word = st_q.alm_cfg;
        else if ({adr[6:1], 1'b0} == ADR_ALM_STATUS) begin
          st_d.rd_word = {st_q.rate, st_q.sleep, st_q.flags};
        end else st_d.rd_word = RST_ZERO;
      end
    end

    // ==========================================================
    // Capture sequencing
    mode = st_q.recording_control[RC_MODE_LO +: 2]; // R11
    case (st_q.state)
      CAC_IDLE: begin
        if (mode == MODE_AUTO_SPECTRUM) begin
          fire = 1'b1;
        end else if (capture_req && capture_mode(mode) && !st_q.sleep) begin
          fire = 1'b1;
        end
      end
      CAC_CAPT: begin
        if (capture_done) begin
          prate = st_q.rate;
          for (int b = 0; b < NUM_BANDS; b++) begin
            peak = band_peak[b*16 +: 16];
            if (peak >= st_q.mem[prate][b][2]) st_d.flags[b] = 1'b1; // R18 R20 R24
            if (peak >= st_q.mem[prate][b][3]) st_d.flags[ST_CRIT_LO + b] = 1'b1; // R24
          end
          if (st_q.alm_cfg[CFG_SYS_EN] && sys_reading >= st_q.sys_lvl) begin
            st_d.flags[ST_SYS] = 1'b1; // R23 R24
          end
          st_d.sleep = st_q.recording_control[RC_PWRDN]; // R5
          st_d.sec_cnt = 25'h0;
          st_d.prd_cnt = 16'h0;
          st_d.state = (mode == MODE_AUTO_SPECTRUM) ? CAC_WAIT : CAC_IDLE;
        end
      end
      CAC_WAIT: begin
        if (mode != MODE_AUTO_SPECTRUM) begin
          st_d.state = CAC_IDLE;
        end else if (st_q.prd_cnt >= st_q.period) begin
          st_d.sleep = 1'b0; // R7
          fire = 1'b1;
        end else if (st_q.sec_cnt == 25'(CYC_PER_SEC - 1)) begin
          st_d.sec_cnt = 25'h0;
          st_d.prd_cnt = st_q.prd_cnt + 16'h1; // R14
        end else begin
          st_d.sec_cnt = st_q.sec_cnt + 25'h1;
        end
      end
      default: st_d.state = CAC_IDLE;
    endcase
    if (fire) begin
      w2[1:0] = next_rate(st_q.recording_control[RC_SREN_LO +: 4], st_q.last_rate); // R2 R4
      st_d.rate = w2[1:0];
      st_d.last_rate = w2[1:0];
      st_d.start = 1'b1;
      st_d.sleep = 1'b0;
      st_d.state = CAC_CAPT;
    end
    if (!capture_mode(mode)) begin
      st_d.rate = 2'h0; // R3
    end
    st_d.stats = st_d.recording_control[RC_STATS] &&
                 (st_d.recording_control[RC_MODE_LO +: 2] == MODE_TIME_CAPTURE); // R8
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.sck <= 1'b1;
      st_q.recording_control <= RST_RECORDING_CONTROL;
      st_q.period <= RST_CAP_PERIOD;
      st_q.last_rate <= RST_LAST_RATE;
      st_q.state <= CAC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign dout = st_q.dout;
  assign capture_start = st_q.start;
  assign capture_rate = st_q.rate;
  assign window_sel = st_q.recording_control[RC_WIN_LO +: 2]; // R1
  assign stats_en = st_q.stats; // R8
  assign velocity_en = st_q.recording_control[RC_VELO]; // R9
  assign store_mode = st_q.recording_control[RC_STORE_LO +: 2]; // R10
  assign op_mode = st_q.recording_control[RC_MODE_LO +: 2]; // R11
  assign sys_temp_sel = st_q.alm_cfg[CFG_SYS_TEMP]; // R23
  assign sleep = st_q.sleep;
endmodule // cac_capture_alarm
`default_nettype wire

// file: rtl/cac_pkg.sv
`default_nettype none
package cac_pkg;
  // ==========================================================
  // Serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int FRM_WR_BIT = 15;
  localparam int FRM_ADDR_HI = 14;
  localparam int FRM_ADDR_LO = 8;
  // ==========================================================
  // Byte addresses; even is low byte, odd is high byte
  localparam logic [6:0] ADR_RECORDING_CONTROL = 7'h1a;
  localparam logic [6:0] ADR_CAP_PERIOD = 7'h1e;
  localparam logic [6:0] ADR_LOW_BIN = 7'h20;
  localparam logic [6:0] ADR_HIGH_BIN = 7'h22;
  localparam logic [6:0] ADR_WARN_LVL = 7'h24;
  localparam logic [6:0] ADR_CRIT_LVL = 7'h26;
  localparam logic [6:0] ADR_ALARM_SELECT_POINTER = 7'h28;
  localparam logic [6:0] ADR_SYS_LVL = 7'h2a;
  localparam logic [6:0] ADR_ALM_CFG = 7'h2c;
  localparam logic [6:0] ADR_ALM_STATUS = 7'h30;
  // ==========================================================
  // Recording control fields
  localparam int RC_WIN_LO = 12;
  localparam int RC_SREN_LO = 8;
  localparam int RC_PWRDN = 7;
  localparam int RC_STATS = 6;
  localparam int RC_VELO = 5;
  localparam int RC_STORE_LO = 2;
  localparam int RC_MODE_LO = 0;
  localparam logic [1:0] WIN_RECT = 2'h0;
  localparam logic [1:0] WIN_HANNING = 2'h1;
  localparam logic [1:0] WIN_FLAT_TOP = 2'h2;
  localparam logic [1:0] MODE_MANUAL_SPECTRUM = 2'h0;
  localparam logic [1:0] MODE_AUTO_SPECTRUM = 2'h1;
  localparam logic [1:0] MODE_TIME_CAPTURE = 2'h2;
  // ==========================================================
  // Pointer, configuration and status fields
  localparam int PNTR_RATE_LO = 8;
  localparam int PNTR_BAND_LO = 0;
  localparam int NUM_RATES = 4;
  localparam int NUM_BANDS = 6;
  localparam int CFG_SYS_TEMP = 4;
  localparam int CFG_SYS_EN = 5;
  localparam int ST_CRIT_LO = 6;
  localparam int ST_SYS = 12;
  localparam int ST_SLEEP = 13;
  localparam int ST_RATE_LO = 14;
  localparam logic [15:0] ST_STICKY_MASK = 16'h1fff;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_RECORDING_CONTROL = 16'h1100;
  localparam logic [15:0] RST_CAP_PERIOD = 16'h0001;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [1:0] RST_LAST_RATE = 2'h3;
  // ==========================================================
  // Timing
  localparam longint CLK_HZ = 20000000;
  localparam longint PERIOD_UNIT_S = 1;
  localparam longint CYC_PER_UNIT = CLK_HZ * PERIOD_UNIT_S;
  typedef enum logic [1:0] {CAC_IDLE, CAC_CAPT, CAC_WAIT} cac_state_t;
endpackage
`default_nettype wire

// file: testbench/cac_capture_alarm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cac_capture_alarm_properties #(
  parameter longint CYC_PER_SEC = 10
) (
  // Clock, reset, select
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  // Capture side
  input wire logic capture_req,
  input wire logic capture_done,
  input wire logic capture_start,
  input wire logic [1:0] capture_rate,
  input wire logic stats_en,
  input wire logic [1:0] op_mode,
  input wire logic sleep
);
  import cac_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Wake-up steps
  sequence cs_wake_s;
    sleep && $fell(cs_n) && op_mode != MODE_AUTO_SPECTRUM;
  endsequence
  sequence awake_s;
    ##[1:3] !sleep;
  endsequence
  start_pulse_a: assert property (capture_start |=> !capture_start)
    else $error("start pulse too long");
  rate_move_a: assert property ($changed(capture_rate) && op_mode != 2'h3
    && $past(op_mode) != 2'h3 |-> capture_start)
    else $error("rate moved without a start");
  mode_off_a: assert property (op_mode == 2'h3 |-> !capture_start)
    else $error("start in unused mode");
  rate_idle_a: assert property ((op_mode == 2'h3) [*2] |-> capture_rate == 2'h0)
    else $error("rate shown outside capture modes");
  stats_mode_a: assert property (stats_en |-> op_mode == MODE_TIME_CAPTURE)
    else $error("statistics outside time capture");
  sleep_rise_a: assert property ($rose(sleep) |-> $past(capture_done))
    else $error("sleep without finished capture");
  cs_wake_a: assert property (cs_wake_s |-> awake_s)
    else $error("select toggle did not wake");
  asleep_a: assert property (sleep && op_mode != MODE_AUTO_SPECTRUM |=> !capture_start)
    else $error("start while asleep");
  manual_req_a: assert property (capture_start && op_mode != MODE_AUTO_SPECTRUM
    |-> $past(capture_req))
    else $error("start without request");
endmodule // cac_capture_alarm_properties
bind cac_capture_alarm cac_capture_alarm_properties #(.CYC_PER_SEC(CYC_PER_SEC)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .capture_req(capture_req),
  .capture_done(capture_done), .capture_start(capture_start), .capture_rate(capture_rate),
  .stats_en(stats_en), .op_mode(op_mode), .sleep(sleep));
`default_nettype wire

// file: testbench/cac_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module cac_spi_host (
  // Clock
  input wire logic ref_clk,
  // Serial lines
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // Three cycles a phase, margin over the two-cycle minimum
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(negedge ref_clk) cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (3) @(negedge ref_clk);
      sclk = 1'b0;
      din = tx[i];
      repeat (3) @(negedge ref_clk);
      rx[i] = dout;
      sclk = 1'b1;
    end
    repeat (3) @(negedge ref_clk);
    cs_n = 1'b1;
    din = ~din;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule // cac_spi_host
`default_nettype wire

// file: testbench/tb_cac_capture_alarm.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cac_capture_alarm;
  import cac_pkg::*;
  logic ref_clk, rst_n, cs_n, sclk, din, dout, capture_req, capture_done;
  logic capture_start, stats_en, velocity_en, sys_temp_sel, sleep;
  logic [1:0] capture_rate, window_sel, store_mode, op_mode;
  logic [95:0] band_peak;
  logic [15:0] sys_reading, rv;
  int num_errors, cmp_count, n;
  cac_capture_alarm #(.CYC_PER_SEC(10)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .capture_req(capture_req), .capture_done(capture_done), .band_peak(band_peak),
    .sys_reading(sys_reading), .capture_start(capture_start), .capture_rate(capture_rate),
    .window_sel(window_sel), .stats_en(stats_en), .velocity_en(velocity_en),
    .store_mode(store_mode), .op_mode(op_mode), .sys_temp_sel(sys_temp_sel), .sleep(sleep));
  cac_spi_host host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Checking and access tasks
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Low byte first, so a mode change lands before the high byte
  task automatic wr(logic [6:0] a, logic [15:0] d);
    logic [15:0] r;
    host.xfer({1'b1, a, d[7:0]}, r);
    host.xfer({1'b1, a + 7'h01, d[15:8]}, r);
  endtask
  task automatic rd(logic [6:0] a, output logic [15:0] d);
    host.xfer({1'b0, a, 8'h00}, d);
    host.xfer({1'b0, a, 8'h00}, d);
  endtask
  task automatic wait_start(int lim);
    n = 0;
    while (capture_start !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic pulse_req();
    @(negedge ref_clk) capture_req = 1'b1;
    @(negedge ref_clk) capture_req = 1'b0;
  endtask
  task automatic done_pulse();
    @(negedge ref_clk) capture_done = 1'b1;
    @(negedge ref_clk) capture_done = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic cap(logic [1:0] rate);
    pulse_req();
    wait_start(20);
    if (n == 20) begin
      num_errors++;
      close_out();
    end else begin
      chk("capture_rate", 16'(rate), 16'(capture_rate));
      done_pulse();
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    capture_req = 1'b0;
    capture_done = 1'b0;
    band_peak = '0;
    sys_reading = 16'h0000;
    num_errors = 0;
    cmp_count = 0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("window_sel", 16'(WIN_HANNING), 16'(window_sel));
    rd(ADR_RECORDING_CONTROL, rv);
    chk("recording_control", 16'h1100, rv);
    rd(ADR_CAP_PERIOD, rv);
    chk("capture_period", 16'h0001, rv);
    rd(7'h40, rv);
    chk("unmapped", 16'h0000, rv);
    $display("test reset done");
    // Automatic mode left out here: it would start at once
    for (int m = 0; m < 3; m += 2) begin
      wr(ADR_RECORDING_CONTROL, {2'h0, 2'(m), 4'h1, 2'b01, 1'(m / 2), 1'b0, 2'(m), 2'(m)});
      chk("window_sel", 16'(m), 16'(window_sel));
      chk("op_mode", 16'(m), 16'(op_mode));
      chk("stats_en", 16'(m == 2), 16'(stats_en));
      chk("velocity_en", 16'(m / 2), 16'(velocity_en));
      chk("store_mode", 16'(m), 16'(store_mode));
    end
    wr(ADR_ALM_CFG, 16'h0010);
    chk("sys_temp_sel", 16'h0001, 16'(sys_temp_sel));
    $display("test fields done");
    wr(ADR_RECORDING_CONTROL, 16'h1500);
    cap(2'h0);
    cap(2'h2);
    cap(2'h0);
    wr(ADR_RECORDING_CONTROL, 16'h1f00);
    cap(2'h1);
    cap(2'h2);
    cap(2'h3);
    cap(2'h0);
    wr(ADR_RECORDING_CONTROL, 16'h1800);
    cap(2'h3);
    cap(2'h3);
    wr(ADR_RECORDING_CONTROL, 16'h1f03);
    pulse_req();
    wait_start(20);
    chk("start in unused mode", 16'd20, 16'(n));
    chk("capture_rate", 16'h0000, 16'(capture_rate));
    $display("test rates done");
    wr(ADR_RECORDING_CONTROL, 16'h1180);
    cap(2'h0);
    chk("sleep", 16'h0001, 16'(sleep));
    pulse_req();
    wait_start(20);
    chk("start while asleep", 16'd20, 16'(n));
    rd(ADR_RECORDING_CONTROL, rv);
    chk("sleep", 16'h0000, 16'(sleep));
    chk("recording_control", 16'h1180, rv);
    wr(ADR_RECORDING_CONTROL, 16'h1100);
    cap(2'h0);
    chk("sleep", 16'h0000, 16'(sleep));
    $display("test sleep done");
    wr(ADR_ALARM_SELECT_POINTER, 16'h0203);
    wr(ADR_LOW_BIN, 16'h0064);
    wr(ADR_ALARM_SELECT_POINTER, 16'h0003);
    rd(ADR_LOW_BIN, rv);
    chk("low bin other alarm", 16'h0000, rv);
    wr(ADR_ALARM_SELECT_POINTER, 16'h0203);
    rd(ADR_LOW_BIN, rv);
    chk("low bin", 16'h0064, rv);
    wr(ADR_ALARM_SELECT_POINTER, 16'hffff);
    rd(ADR_ALARM_SELECT_POINTER, rv);
    chk("pointer", 16'h0307, rv);
    $display("test pointer done");
    wr(ADR_ALARM_SELECT_POINTER, 16'h0000);
    wr(ADR_WARN_LVL, 16'h0100);
    wr(ADR_CRIT_LVL, 16'h0200);
    wr(ADR_ALM_STATUS, 16'hffff);
    band_peak = 96'h100;
    cap(2'h0);
    rd(ADR_ALM_STATUS, rv);
    chk("alarm status", 16'h0fbf, rv);
    $display("test alarm done");
    wr(ADR_CAP_PERIOD, 16'h0002);
    wr(ADR_RECORDING_CONTROL, 16'h1181);
    done_pulse();
    chk("sleep", 16'h0001, 16'(sleep));
    wait_start(60);
    chk("period gap", 16'h0001, 16'(n > 14 && n < 24));
    chk("sleep", 16'h0000, 16'(sleep));
    $display("test auto done");
    close_out();
  end
endmodule // tb_cac_capture_alarm
`default_nettype wire
